// ### rtl/cir_responder.sv
/*
 Identification responder: software writes a selector, the block answers with
 four constant result words. Assumes an APB master on pclk with presetn.
*/
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
module cir_responder
   import cir_pkg::*;
#(
   // Identification words: arbitrary neutral values
   parameter logic [31:0] VENDOR_B = 32'h4142_4344,
   parameter logic [31:0] VENDOR_D = 32'h4546_4748,
   parameter logic [31:0] VENDOR_C = 32'h494A_4B4C,
   parameter logic [3:0] STEPPING = 4'h0,
   parameter logic [3:0] MODEL = 4'h1,
   parameter logic [3:0] FAMILY = 4'h6,
   parameter logic [1:0] PTYPE = 2'h0,
   // Bits 0..6 are defined elsewhere; supplied as a parameter
   parameter logic [6:0] LOW_FLAGS = 7'h00,
   parameter bit HAS_MCE = 1'b1,
   parameter bit HAS_CX8 = 1'b1,
   parameter bit HAS_PIC = 1'b1,
   parameter bit HAS_MTR = 1'b1,
   parameter bit HAS_GPG = 1'b1,
   parameter bit HAS_MCA = 1'b1,
   parameter bit HAS_CMV = 1'b1
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   // ------------------------------------------------------------
   // Parameter checks
   // ------------------------------------------------------------
   if (PTYPE == 2'h3)
   begin : g_bad_ptype
      $error("Processor type code 3 is reserved");
   end

   // ------------------------------------------------------------
   // Constant answers
   // ------------------------------------------------------------
   logic [31:0] flags_w;
   logic [31:0] version_w;

   // Flag word, one bit per capability; others stay zero
   always_comb
   begin
      flags_w = 32'h0000_0000;
      flags_w[6:0] = LOW_FLAGS;
      flags_w[CIR_FB_MCE] = HAS_MCE;
      flags_w[CIR_FB_CX8] = HAS_CX8;
      flags_w[CIR_FB_PIC] = HAS_PIC;
      flags_w[CIR_FB_MTR] = HAS_MTR;
      flags_w[CIR_FB_GPG] = HAS_GPG;
      flags_w[CIR_FB_MCA] = HAS_MCA;
      flags_w[CIR_FB_CMV] = HAS_CMV;
   end

   // Version word; bits above 13 reserved as zero
   always_comb
   begin
      version_w = 32'h0000_0000;
      version_w[CIR_STEP_LSB +: 4] = STEPPING;
      version_w[CIR_MODEL_LSB +: 4] = MODEL;
      version_w[CIR_FAMILY_LSB +: 4] = FAMILY;
      version_w[CIR_PTYPE_LSB +: 2] = PTYPE;
   end

   // Answer table; cache words have bit 31 clear, so all are valid
   function automatic cir_result_s answer(input logic [31:0] s);
      cir_result_s r;
      r = '{a: CIR_RSVD_WORD, b: CIR_RSVD_WORD, c: CIR_RSVD_WORD, d: CIR_RSVD_WORD};
      if (s == CIR_SEL_VENDOR)
      begin
         r.a = CIR_MAX_SEL;
         r.b = VENDOR_B;
         r.d = VENDOR_D;
         r.c = VENDOR_C;
      end
      else if (s == CIR_SEL_VERSION)
      begin
         r.a = version_w;
         r.d = flags_w;
      end
      else if (s == CIR_SEL_CACHE)
      begin
         // One byte per descriptor, low byte of A is the iteration count
         r.a = {CIR_DSC_DTB_4K, CIR_DSC_ITB_4M, CIR_DSC_ITB_4K, CIR_CACHE_ITER};
         r.b = {4{CIR_DSC_NULL}};
         r.c = {4{CIR_DSC_NULL}};
         r.d = {CIR_DSC_IC_8K, CIR_DSC_DTB_4M, CIR_DSC_DC_8K, CIR_DSC_UC_256K};
      end
      return r;
   endfunction : answer

   // ------------------------------------------------------------
   // State and APB slave
   // ------------------------------------------------------------
   cir_state_s s_q;
   cir_state_s s_d;
   logic setup_w;

   assign setup_w = psel & ~penable;

   // Answer in access phase with no wait state, decided at setup
   always_comb
   begin
      s_d = s_q;
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;
      if (setup_w)
      begin
         // Decode here so the access phase sees a registered answer
         s_d.pready = 1'b1;
         s_d.prdata = 32'h0000_0000;
         unique case (paddr)
            CIR_OFF_SEL: s_d.prdata = s_q.sel;
            CIR_OFF_REG_A: s_d.prdata = s_q.res.a;
            CIR_OFF_REG_B: s_d.prdata = s_q.res.b;
            CIR_OFF_REG_C: s_d.prdata = s_q.res.c;
            CIR_OFF_REG_D: s_d.prdata = s_q.res.d;
            CIR_OFF_STATUS: s_d.prdata = {31'h0000_0000, s_q.done};
            default: s_d.pslverr = 1'b1;
         endcase
         if (pwrite && paddr != CIR_OFF_SEL)
         begin
            s_d.pslverr = 1'b1; // Results are read-only
         end
      end
      else if (psel && penable && s_q.pready && pwrite && !s_q.pslverr)
      begin
         // Selector write issues the request; results follow next edge
         s_d.sel = pwdata;
         s_d.res = answer(pwdata);
         s_d.done = 1'b1;
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         // Reset selector is 0, so the results must already hold its answer
         s_q <= '{sel: CIR_SEL_RESET,
                  res: '{a: CIR_MAX_SEL, b: VENDOR_B, c: VENDOR_C, d: VENDOR_D},
                  prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0, done: 1'b0};
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;

endmodule : cir_responder

// ### rtl/cir_pkg.sv
/*
 Constants, register map and carrier types for the identification responder.
 Assumes an APB master on pclk/presetn and 32-bit data.
*/
// Summary of operation
// - Selector 0: highest selector 2, vendor string
// - Selector 1: stepping, model, family, type fields
// - Selector 1: flags in D, B/C reserved
// - Bit 7: machine check enable supported
// - Bit 8: eight-byte compare-exchange supported
// - Bit 9: interrupt controller present and enabled
// - Bit 12: memory type range registers present
// - Bit 13: global page enable supported
// - Bit 14: machine check capability register present
// - Bit 15: conditional move supported
// - Selector 2 fills all four results
// - Selector 2: low byte of A is 1
// - Selector 2: bit 31 zero means valid
// - Valid registers carry one-byte descriptors
// - Codes 00H, 01H, 02H defined
// - Codes 03H, 04H, 0AH defined
// - Codes 06H, 41H, 42H, 43H defined
// - Selector 2 values: A 03020101H, D 06040A42H
// - Higher selectors return reserved undefined data
// - Flag one means feature supported
package cir_pkg;

   // ------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [11:0] CIR_OFF_SEL = 12'h000;
   localparam logic [11:0] CIR_OFF_REG_A = 12'h004;
   localparam logic [11:0] CIR_OFF_REG_B = 12'h008;
   localparam logic [11:0] CIR_OFF_REG_C = 12'h00C;
   localparam logic [11:0] CIR_OFF_REG_D = 12'h010;
   localparam logic [11:0] CIR_OFF_STATUS = 12'h014;

   // ------------------------------------------------------------
   // Selectors and fixed answers
   // ------------------------------------------------------------
   localparam logic [31:0] CIR_SEL_VENDOR = 32'h0000_0000;
   localparam logic [31:0] CIR_SEL_VERSION = 32'h0000_0001;
   localparam logic [31:0] CIR_SEL_CACHE = 32'h0000_0002;
   localparam logic [31:0] CIR_MAX_SEL = 32'h0000_0002;
   localparam logic [31:0] CIR_SEL_RESET = 32'h0000_0000;

   // Version field positions
   localparam int CIR_STEP_LSB = 0;
   localparam int CIR_MODEL_LSB = 4;
   localparam int CIR_FAMILY_LSB = 8;
   localparam int CIR_PTYPE_LSB = 12;

   // Feature flag positions
   localparam int CIR_FB_MCE = 7;
   localparam int CIR_FB_CX8 = 8;
   localparam int CIR_FB_PIC = 9;
   localparam int CIR_FB_MTR = 12;
   localparam int CIR_FB_GPG = 13;
   localparam int CIR_FB_MCA = 14;
   localparam int CIR_FB_CMV = 15;

   // Cache descriptor codes
   localparam logic [7:0] CIR_DSC_NULL = 8'h00;
   localparam logic [7:0] CIR_DSC_ITB_4K = 8'h01;
   localparam logic [7:0] CIR_DSC_ITB_4M = 8'h02;
   localparam logic [7:0] CIR_DSC_DTB_4K = 8'h03;
   localparam logic [7:0] CIR_DSC_DTB_4M = 8'h04;
   localparam logic [7:0] CIR_DSC_IC_8K = 8'h06;
   localparam logic [7:0] CIR_DSC_DC_8K = 8'h0A;
   localparam logic [7:0] CIR_DSC_UC_128K = 8'h41;
   localparam logic [7:0] CIR_DSC_UC_256K = 8'h42;
   localparam logic [7:0] CIR_DSC_UC_512K = 8'h43;
   localparam logic [7:0] CIR_CACHE_ITER = 8'h01;

   // Undefined content for reserved answers is pinned to this value
   localparam logic [31:0] CIR_RSVD_WORD = 32'h0000_0000;

   // Result quadruple
   typedef struct packed {
      logic [31:0] a;
      logic [31:0] b;
      logic [31:0] c;
      logic [31:0] d;
   } cir_result_s;

   // Whole module state
   typedef struct packed {
      logic [31:0] sel;
      cir_result_s res;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic done;
   } cir_state_s;

endpackage : cir_pkg

// ### tb/cir_properties.sv
/* Concurrent checks on the responder's APB answers and fixed words.
 Assumes it is bound to cir_responder built with default parameters. */
`timescale 1ns/1ps
module cir_properties
   import cir_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // ------------------------------------------------------------
   // Selector shadow and checks
   // ------------------------------------------------------------
   logic [31:0] sel_q;
   function automatic logic rd(input logic [11:0] a);
      return psel && !penable && !pwrite && paddr == a;
   endfunction : rd
   // Shadow moves only on a completed write, so reads see the stored selector
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sel_q <= CIR_SEL_RESET;
      else if (pready && pwrite && paddr == CIR_OFF_SEL)
         sel_q <= pwdata;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   setup_ready_a: assert property (psel && !penable |=> pready) else $error("no answer");
   ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
   err_ready_a: assert property (pslverr |-> pready && psel) else $error("stray pslverr");
   bad_addr_a: assert property (psel && !penable && paddr > CIR_OFF_STATUS
      |=> pslverr && prdata == 32'h0) else $error("unmapped accepted");
   max_sel_a: assert property (rd(CIR_OFF_REG_A) && sel_q == CIR_SEL_VENDOR
      |=> prdata == CIR_MAX_SEL) else $error("bad highest selector");
   version_a: assert property (rd(CIR_OFF_REG_A) && sel_q == CIR_SEL_VERSION
      |=> prdata[31:14] == 18'h0) else $error("version reserved bits");
   flags_a: assert property (rd(CIR_OFF_REG_D) && sel_q == CIR_SEL_VERSION
      |=> prdata[31:7] == 25'h00001E7) else $error("bad flag word");
   cache_a_a: assert property (rd(CIR_OFF_REG_A) && sel_q == CIR_SEL_CACHE
      |=> prdata == 32'h0302_0101) else $error("bad cache word A");
   cache_d_a: assert property (rd(CIR_OFF_REG_D) && sel_q == CIR_SEL_CACHE
      |=> prdata == 32'h0604_0A42) else $error("bad cache word D");
   cache_bc_a: assert property ((rd(CIR_OFF_REG_B) || rd(CIR_OFF_REG_C))
      && sel_q == CIR_SEL_CACHE |=> prdata == 32'h0) else $error("bad cache word B or C");
   cover property (rd(CIR_OFF_REG_A) && sel_q == CIR_SEL_CACHE);
   cover property (rd(CIR_OFF_REG_D) && sel_q == CIR_SEL_VERSION);
   cover property (pslverr);
endmodule : cir_properties

bind cir_responder cir_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr));

// ### tb/cir_requester.sv
/* Requester model: issues identification requests as an APB master.
 Assumes the responder answers with pready and nothing else stalls it. */
`timescale 1ns/1ps
module cir_requester (
   input wire logic pclk,
   output logic psel = 1'b0,
   output logic penable = 1'b0,
   output logic pwrite = 1'b0,
   output logic [11:0] paddr = 12'h000,
   output logic [31:0] pwdata = 32'h0,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // One transfer; answer is taken at the rising edge that sees pready high
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a; // Released bus shows junk, not the old request
      pwdata <= ~d;
   endtask : xfer
endmodule : cir_requester

// ### tb/tb_top.sv
/* Self-checking bench for the identification responder.
 Assumes default design parameters and the requester model as bus master. */
`timescale 1ns/1ps
module tb_top
   import cir_pkg::*;
;
   // ------------------------------------------------------------
   // Clock, reset, wiring
   // ------------------------------------------------------------
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   int fail_count = 0;
   int n_tests = 0;
   always #2.5 pclk = ~pclk;
   cir_requester u_req (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   cir_responder u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      u_req.xfer(1'b0, a, 32'h0, r, e);
      chk("prdata", r, exp);
   endtask : rd
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic err);
      logic [31:0] r;
      logic e;
      u_req.xfer(1'b1, a, d, r, e);
      chk("pslverr", {31'h0, e}, {31'h0, err});
   endtask : wr
   // Vendor words are the design's arbitrary defaults
   task automatic t_vendor;
      rd(CIR_OFF_SEL, CIR_SEL_RESET);
      rd(CIR_OFF_REG_A, 32'h0000_0002);
      rd(CIR_OFF_REG_B, 32'h4142_4344);
      rd(CIR_OFF_REG_D, 32'h4546_4748);
      rd(CIR_OFF_REG_C, 32'h494A_4B4C);
   endtask : t_vendor
   task automatic t_version;
      wr(CIR_OFF_SEL, CIR_SEL_VERSION, 1'b0);
      rd(CIR_OFF_REG_A, 32'h0000_0610);
      rd(CIR_OFF_REG_D, 32'h0000_F380);
   endtask : t_version
   task automatic t_cache;
      wr(CIR_OFF_SEL, CIR_SEL_CACHE, 1'b0);
      rd(CIR_OFF_REG_A, 32'h0302_0101);
      rd(CIR_OFF_REG_B, 32'h0);
      rd(CIR_OFF_REG_C, 32'h0);
      rd(CIR_OFF_REG_D, 32'h0604_0A42);
   endtask : t_cache
   // Refused writes must leave the cache answer intact
   task automatic t_refuse;
      wr(12'h018, 32'h1, 1'b1);
      wr(CIR_OFF_REG_A, 32'h0, 1'b1);
      rd(12'h018, 32'h0);
      rd(CIR_OFF_REG_A, 32'h0302_0101);
   endtask : t_refuse
   task automatic results;
      if (fail_count == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : results
   // Run is about 70 cycles; the watchdog allows ample margin
   initial
   begin
      repeat (5000) @(posedge pclk);
      fail_count++;
      results();
   end
   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_vendor();
      t_version();
      t_cache();
      t_refuse();
      results();
   end
endmodule : tb_top
